// ===== amcr_regs.sv
// Alert mask, status flags, conversion rate, one-shot and ID registers.
// Assumes the serial bus engine drives the register port on ref_clk.
`timescale 1ns/1ps
module amcr_regs
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Alarm conditions from the comparators
    input wire logic busy,
    input wire logic local_high_cond,
    input wire logic remote_high_cond,
    input wire logic remote_low_cond,
    input wire logic diode_fault_cond,
    input wire logic critical_temperature_limit_cond,
    input wire logic [amcr_pkg::TACH_W-1:0] tach_count,
    input wire logic [amcr_pkg::TACH_W-1:0] tach_limit,
    // Mode
    input wire logic standby,
    input wire logic pin_tach_mode,
    // Outputs
    output logic alert,
    output logic [7:0] conv_rate_code,
    output logic conv_start
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Alarm flags
    // ------------------------------------------------------------
    logic tach_cond;
    logic status_clr;
    logic [5:0] cond_v;
    logic [5:0] flag_v;
    logic [7:0] status;

    // (R2) Fan slower than minimum
    // (R1) Within limit leaves no cause
    assign tach_cond = tach_count > tach_limit;
    // (R14) Reading status clears gone alarms
    assign status_clr = reg_rd && (reg_addr == amcr_pkg::ADDR_STATUS);
    assign cond_v = {local_high_cond, remote_high_cond, remote_low_cond,
                     diode_fault_cond, critical_temperature_limit_cond, tach_cond};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_flag
            amcr_flag u_flag
            (
                .clk(ref_clk),
                .rst_n(rst_n_r),
                .cond(cond_v[gi]),
                .clr(status_clr),
                .flag(flag_v[gi])
            );
        end
    endgenerate

    assign status = {busy, flag_v[5], 1'b0, flag_v[4], flag_v[3], flag_v[2],
                     flag_v[1], flag_v[0]};

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] rate_r;
    logic [7:0] rate_nxt;
    logic [7:0] code_r;
    logic [7:0] code_nxt;
    logic alert_r;
    logic alert_nxt;
    logic start_r;
    logic start_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [7:0] alert_src;

    always_comb
    begin
        mask_nxt = mask_r;
        rate_nxt = rate_r;
        if (reg_wr && reg_addr == amcr_pkg::ADDR_ALERT_MASK)
            // (R9) Unused bits forced to one
            mask_nxt = reg_wdata | amcr_pkg::MASK_UNUSED_ONES;
        if (reg_wr && (reg_addr == amcr_pkg::ADDR_CONV_RATE ||
                       reg_addr == amcr_pkg::ADDR_CONV_RATE_WR))
            rate_nxt = reg_wdata;
        // (R10) Rate code to the sequencer
        // (R11) Clamp to fastest rate
        code_nxt = (rate_r > amcr_pkg::CONV_RATE_MAX) ? amcr_pkg::CONV_RATE_MAX : rate_r;
        // (R12) Any one-shot write in standby starts one
        start_nxt = reg_wr && standby && (reg_addr == amcr_pkg::ADDR_ONE_SHOT);
        // (R4) (R5) (R6) (R7) (R8) Masked flag sources
        alert_src = status & ~mask_r & amcr_pkg::ALERT_SOURCES;
        // (R3) Shared pin is a tach input
        if (pin_tach_mode)
            alert_src[amcr_pkg::BIT_TACH] = 1'b0;
        // (R15) Any unmasked flag drives alert, save tach in tach-pin mode
        alert_nxt = |alert_src;
        rvalid_nxt = reg_rd;
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                amcr_pkg::ADDR_STATUS: rdata_nxt = status;
                amcr_pkg::ADDR_CONV_RATE: rdata_nxt = rate_r;
                amcr_pkg::ADDR_ALERT_MASK: rdata_nxt = mask_r;
                // (R13) Fixed identification values
                amcr_pkg::ADDR_MAKER_ID: rdata_nxt = amcr_pkg::MAKER_ID_VAL;
                amcr_pkg::ADDR_DIE_REV_ID: rdata_nxt = amcr_pkg::DIE_REV_ID_VAL;
                // (R16) One-shot reads zero, no start
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            mask_r <= amcr_pkg::MASK_RESET;
            rate_r <= amcr_pkg::CONV_RATE_RESET;
            code_r <= amcr_pkg::CONV_RATE_RESET;
            alert_r <= 1'b0;
            start_r <= 1'b0;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            mask_r <= mask_nxt;
            rate_r <= rate_nxt;
            code_r <= code_nxt;
            alert_r <= alert_nxt;
            start_r <= start_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign alert = alert_r;
    assign conv_rate_code = code_r;
    assign conv_start = start_r;
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_r);

    property p_tach_clear;
        status_clr && !tach_cond |=> !flag_v[0];
    endproperty
    a_tach_clear: assert property (p_tach_clear) else $error("tach flag not cleared"); // (R1)

    property p_tach_set;
        tach_cond |=> flag_v[0];
    endproperty
    a_tach_set: assert property (p_tach_set) else $error("tach flag not set"); // (R2)

    property p_tach_no_alert;
        pin_tach_mode && (status & ~mask_r & 8'h5a) == 8'h00 |=> !alert;
    endproperty
    a_tach_no_alert: assert property (p_tach_no_alert) else $error("tach gave alert"); // (R3)

    property p_local_alert;
        flag_v[5] && !mask_r[6] |=> alert;
    endproperty
    a_local_alert: assert property (p_local_alert) else $error("local alert missing"); // (R4)

    property p_crit_alert;
        flag_v[1] && !mask_r[1] |=> alert;
    endproperty
    a_crit_alert: assert property (p_crit_alert) else $error("critical alert missing"); // (R7)

    property p_mask_ones;
        (mask_r & amcr_pkg::MASK_UNUSED_ONES) == amcr_pkg::MASK_UNUSED_ONES;
    endproperty
    a_mask_ones: assert property (p_mask_ones) else $error("unused mask bit low"); // (R9)

    property p_rate_clamp;
        ##1 conv_rate_code == (($past(rate_r) > 8'h09) ? 8'h09 : $past(rate_r));
    endproperty
    a_rate_clamp: assert property (p_rate_clamp) else $error("rate code wrong"); // (R11)

    sequence s_shot_write;
        reg_wr && standby && reg_addr == amcr_pkg::ADDR_ONE_SHOT;
    endsequence
    property p_one_shot;
        s_shot_write |=> conv_start ##1 (!conv_start || $past(start_nxt));
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot start wrong"); // (R12)

    property p_id_read;
        reg_rd && reg_addr == amcr_pkg::ADDR_MAKER_ID |=>
            reg_rvalid && reg_rdata == amcr_pkg::MAKER_ID_VAL;
    endproperty
    a_id_read: assert property (p_id_read) else $error("maker id wrong"); // (R13)

    property p_alert_release;
        (alert_src == 8'h00) |=> !alert;
    endproperty
    a_alert_release: assert property (p_alert_release) else $error("alert stuck"); // (R15)

    property p_shot_read;
        !reg_wr |=> !conv_start;
    endproperty
    a_shot_read: assert property (p_shot_read) else $error("start without write"); // (R16)
endmodule : amcr_regs

// ===== amcr_pkg.sv
// Constants for the alert mask, conversion rate and ID register bank.
// Assumes a same-clock register port from the serial bus engine.
// Notes on behaviour
// (R1) Tach flag clears on status read once count within limit
// (R2) Tach count above limit sets tach flag
// (R3) Tach alarm gives no alert in tach-pin mode
// (R4) Mask bit 6 gates local high alert
// (R5) Mask bit 4 gates remote high alert
// (R6) Mask bit 3 gates remote low alert
// (R7) Mask bit 1 gates remote critical alert
// (R8) Mask bit 0 gates tach alert
// (R9) Unused mask bits read one; used reset zero
// (R10) Rate code doubles per step; resets to 0x08
// (R11) Codes above nine act as 32 Hz
// (R12) Standby one-shot write starts one conversion
// (R13) Two read-only ID registers at top addresses
// (R14) Flags latch until status read, condition gone
// (R15) Alert follows any unmasked latched flag except tach in tach-pin mode
// (R16) One-shot address read has no effect
package amcr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CONV_RATE = 8'h04;
    localparam logic [7:0] ADDR_CONV_RATE_WR = 8'h0a;
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;
    localparam logic [7:0] ADDR_ALERT_MASK = 8'h16;
    localparam logic [7:0] ADDR_MAKER_ID = 8'hfe;
    localparam logic [7:0] ADDR_DIE_REV_ID = 8'hff;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int BIT_BUSY = 7;
    localparam int BIT_LOCAL_HIGH = 6;
    localparam int BIT_REMOTE_HIGH = 4;
    localparam int BIT_REMOTE_LOW = 3;
    localparam int BIT_DIODE_FAULT = 2;
    localparam int BIT_REMOTE_CRIT = 1;
    localparam int BIT_TACH = 0;
    localparam logic [7:0] MASK_UNUSED_ONES = 8'ha4;
    localparam logic [7:0] MASK_RESET = 8'ha4;
    localparam logic [7:0] ALERT_SOURCES = 8'h5b;
    localparam logic [7:0] CONV_RATE_RESET = 8'h08;
    localparam logic [7:0] CONV_RATE_MAX = 8'h09;
    localparam int TACH_W = 16;
    // Arbitrary identification values
    localparam logic [7:0] MAKER_ID_VAL = 8'h5a;
    localparam logic [7:0] DIE_REV_ID_VAL = 8'h03;
endpackage : amcr_pkg

// ===== amcr_flag.sv
// One latched alarm flag.
// Assumes cond and clr come from logic on the same clock.
`timescale 1ns/1ps
module amcr_flag
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Alarm condition and read clear
    input wire logic cond,
    input wire logic clr,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    // (R14) Set wins over read clear
    always_comb
    begin
        flag_nxt = cond | (flag_r & ~clr);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

    assign flag = flag_r;
endmodule : amcr_flag

// ===== amcr_host.sv
// Host model: single-byte reads and writes on the register port.
// Assumes the port answers a read exactly one cycle after its strobe edge.
`timescale 1ns/1ps
module amcr_host
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse, so a stale copy is never trusted
    task wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~dat;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] dat, output logic ok);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge ref_clk);
        dat = reg_rdata;
        ok = reg_rvalid;
    endtask : rd
endmodule : amcr_host

// ===== amcr_regs_tb.sv
// Testbench for the alert mask, rate, one-shot and ID registers.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module amcr_regs_tb;
    logic ref_clk;
    logic rstn;
    logic busy;
    logic fault;
    logic [3:0] cond;
    logic [amcr_pkg::TACH_W-1:0] tach_count;
    logic [amcr_pkg::TACH_W-1:0] tach_limit;
    logic standby;
    logic pin_tach_mode;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic alert;
    logic [7:0] conv_rate_code;
    logic conv_start;
    logic [7:0] m;
    int mismatches;
    int n_checks;
    int n_starts;
    int bits [5] = '{6, 4, 3, 1, 0};
    amcr_regs dut (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .busy(busy), .local_high_cond(cond[0]),
        .remote_high_cond(cond[1]), .remote_low_cond(cond[2]), .diode_fault_cond(fault),
        .critical_temperature_limit_cond(cond[3]), .tach_count(tach_count),
        .tach_limit(tach_limit), .standby(standby), .pin_tach_mode(pin_tach_mode),
        .alert(alert), .conv_rate_code(conv_rate_code), .conv_start(conv_start));
    amcr_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (conv_start === 1'b1)
            n_starts <= n_starts + 1;
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask : rdc
    // Source 4 is the tach path; off means count equal to limit
    task alarm(input int i, input logic on);
        @(posedge ref_clk);
        if (i == 4)
            tach_count <= on ? 16'h0101 : 16'h0100;
        else
            cond[i] <= on;
    endtask : alarm
    task alert_is(input logic exp);
        repeat (3) @(negedge ref_clk);
        check({7'h00, alert}, {7'h00, exp});
    endtask : alert_is
    task finish_test;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial
    begin
        #200000;
        mismatches++;
        finish_test;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        busy = 1'b0;
        fault = 1'b0;
        cond = 4'h0;
        tach_count = 16'h0100;
        tach_limit = 16'h0100;
        standby = 1'b0;
        pin_tach_mode = 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rdc(amcr_pkg::ADDR_ALERT_MASK, 8'ha4);
        rdc(amcr_pkg::ADDR_CONV_RATE, 8'h08);
        check(conv_rate_code, 8'h08);
        host.wr(amcr_pkg::ADDR_MAKER_ID, 8'h00);
        rdc(amcr_pkg::ADDR_MAKER_ID, amcr_pkg::MAKER_ID_VAL);
        rdc(amcr_pkg::ADDR_DIE_REV_ID, amcr_pkg::DIE_REV_ID_VAL);
        host.wr(amcr_pkg::ADDR_ONE_SHOT, 8'h00);
        rdc(amcr_pkg::ADDR_ONE_SHOT, 8'h00);
        rdc(8'h10, 8'h00);
        check(n_starts[7:0], 8'h00);
        host.wr(amcr_pkg::ADDR_ALERT_MASK, 8'h00);
        rdc(amcr_pkg::ADDR_ALERT_MASK, 8'ha4);
        for (int c = 0; c < 13; c++)
        begin
            host.wr(c[0] ? amcr_pkg::ADDR_CONV_RATE_WR : amcr_pkg::ADDR_CONV_RATE, c[7:0]);
            rdc(amcr_pkg::ADDR_CONV_RATE, c[7:0]);
            check(conv_rate_code, (c > 9) ? 8'h09 : c[7:0]);
        end
        for (int i = 0; i < 5; i++)
        begin
            m = 8'hff ^ (8'h01 << bits[i]);
            host.wr(amcr_pkg::ADDR_ALERT_MASK, m);
            alarm(i, 1'b1);
            alert_is(1'b1);
            alarm(i, 1'b0);
            rdc(amcr_pkg::ADDR_STATUS, 8'h01 << bits[i]);
            alert_is(1'b0);
            rdc(amcr_pkg::ADDR_STATUS, 8'h00);
            host.wr(amcr_pkg::ADDR_ALERT_MASK, 8'hff);
            alarm(i, 1'b1);
            alert_is(1'b0);
            alarm(i, 1'b0);
            rdc(amcr_pkg::ADDR_STATUS, 8'h01 << bits[i]);
        end
        @(posedge ref_clk);
        pin_tach_mode <= 1'b1;
        host.wr(amcr_pkg::ADDR_ALERT_MASK, 8'h00);
        alarm(4, 1'b1);
        alert_is(1'b0);
        alarm(4, 1'b0);
        rdc(amcr_pkg::ADDR_STATUS, 8'h01);
        // Read while the condition stands must keep the flag
        alarm(0, 1'b1);
        rdc(amcr_pkg::ADDR_STATUS, 8'h40);
        rdc(amcr_pkg::ADDR_STATUS, 8'h40);
        alert_is(1'b1);
        alarm(0, 1'b0);
        rdc(amcr_pkg::ADDR_STATUS, 8'h40);
        rdc(amcr_pkg::ADDR_STATUS, 8'h00);
        // Diode fault latches but never alerts; busy is live
        @(posedge ref_clk);
        fault <= 1'b1;
        busy <= 1'b1;
        alert_is(1'b0);
        @(posedge ref_clk);
        fault <= 1'b0;
        rdc(amcr_pkg::ADDR_STATUS, 8'h84);
        @(posedge ref_clk);
        busy <= 1'b0;
        rdc(amcr_pkg::ADDR_STATUS, 8'h00);
        @(posedge ref_clk);
        standby <= 1'b1;
        host.wr(amcr_pkg::ADDR_ONE_SHOT, 8'h00);
        repeat (3) @(negedge ref_clk);
        check(n_starts[7:0], 8'h01);
        host.wr(amcr_pkg::ADDR_ONE_SHOT, 8'h5c);
        host.wr(amcr_pkg::ADDR_ONE_SHOT, 8'hff);
        rdc(amcr_pkg::ADDR_ONE_SHOT, 8'h00);
        // A start launched by the read would be counted by now
        repeat (2) @(negedge ref_clk);
        check(n_starts[7:0], 8'h03);
        // Mid-run reset restores mask and rate
        host.wr(amcr_pkg::ADDR_ALERT_MASK, 8'hff);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(conv_rate_code, 8'h08);
        check({7'h00, alert}, 8'h00);
        rdc(amcr_pkg::ADDR_CONV_RATE, 8'h08);
        rdc(amcr_pkg::ADDR_ALERT_MASK, 8'ha4);
        rdc(amcr_pkg::ADDR_STATUS, 8'h00);
        finish_test;
    end
endmodule : amcr_regs_tb
